// ==== design/key_debounce.v ====
// three-key debouncer: the key levels are accepted after all three hold steady for the full window
`timescale 1ns/10ps
`include "motion_status_map.vh"
module key_debounce (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clk_en,
  // keys
  input  wire [2:0] key_raw,
  output reg  [2:0] key_clean_r
);
  reg [2:0]  key_seen_r;
  reg [15:0] count_r;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      key_seen_r  <= 3'h0;
      key_clean_r <= 3'h0;
      count_r     <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (key_raw != key_seen_r)
      begin
        key_seen_r <= key_raw;
        count_r    <= 16'h0000;
      end
      else if (count_r == `DEBOUNCE_CYCLES - 1)
        key_clean_r <= key_seen_r;
      else
        count_r <= count_r + 16'h0001;
    end
  end
endmodule // key_debounce

// ==== design/motion_status_map.vh ====
// register offsets, field positions, reset values and timing counts for the motion status readout
`ifndef MOTION_STATUS_MAP_VH
`define MOTION_STATUS_MAP_VH
`define OFF_REVISION      8'h01
`define OFF_KEY_STATE     8'h02
`define OFF_HORIZ_LOW     8'h03
`define OFF_VERT_LOW      8'h04
`define OFF_MOTION_UPPER  8'h05
`define OFF_WHEEL_COUNT   8'h06
`define OFF_SURFACE_COUNT 8'h07
`define OFF_EXPOSURE_UP   8'h08
`define OFF_EXPOSURE_LOW  8'h09
`define RST_MOTION        8'h00
`define RST_WHEEL         8'h00
`define RST_SURFACE       8'h00
`define RST_EXPOSURE      16'h0064
`define RST_EXPOSURE_LO   8'h64
`define REVISION_VALUE    8'h01
`define SURFACE_MAX       8'h80
`define WHEEL_MAX         8'h7f
`define WHEEL_MIN         8'h81
`define KEY_FIELD_LSB     0
`define KEY_FIELD_W       3
`define X_UPPER_LSB       4
`define Y_UPPER_LSB       0
`define DEBOUNCE_TIME_US  5
`define CLK_MHZ           40
`define DEBOUNCE_CYCLES   (`DEBOUNCE_TIME_US * `CLK_MHZ)
`endif

// ==== design/motion_status_readout.v ====
// read-only diagnostic register group: revision, keys, motion mirror, wheel, surface and exposure
`timescale 1ns/10ps
`include "motion_status_map.vh"
// Notes on behaviour
// [RQ1] revision register returns a fixed silicon revision value
// [RQ2] each of three keys in its own low bit, 1 pressed, 0 open
// [RQ3] key bits come from debounced key signals, not raw levels
// [RQ4] host uses these mirrors only for test; navigation via HID reports
// [RQ5] horizontal low holds low 8 bits of latest sent or queued X
// [RQ6] vertical low holds low 8 bits of latest sent or queued Y
// [RQ7] upper register: X[11:8] in bits 7..4, Y[11:8] in bits 3..0
// [RQ8] Y low and upper read zero unless X low was read first
// [RQ9] motion is two's complement, scaled by the selected resolution
// [RQ10] wheel count accumulates, saturating between -127 and +127
// [RQ11] surface register reports features seen in current frame
// [RQ12] surface register never reports above 128
// [RQ13] exposure pair is a 16-bit shutter-open clock count, upper and lower
// [RQ14] upper exposure read freezes lower byte so the pair stays consistent
// [RQ15] registers reached through USB port; unreachable after bus reset
// [RQ16] key reserved bits read zero; writes have no effect
// [RQ17] wheel count presented as 8-bit two's complement
module motion_status_readout (
  // clock, reset, enable
  input  wire        clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // register port from the usb endpoint logic
  input  wire        usb_bus_reset,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_r,
  output reg         reg_rvalid_r,
  // keys and wheel
  input  wire [2:0]  key_raw,
  input  wire        wheel_a,
  input  wire        wheel_b,
  // report path and imaging
  input  wire        report_load,
  input  wire [11:0] report_dx,
  input  wire [11:0] report_dy,
  input  wire        frame_done,
  input  wire [7:0]  frame_features,
  input  wire [15:0] frame_exposure
);
  wire [2:0]  key_clean;
  wire [7:0]  wheel_val;
  reg  [11:0] dx_r;
  reg  [11:0] dy_r;
  reg         x_read_r;
  reg  [7:0]  surface_r;
  reg  [15:0] exposure_r;
  reg  [7:0]  exp_low_hold_r;
  reg         exp_pair_open_r;
  reg         usb_live_r;
  reg  [7:0]  rdata_nxt;
  wire        rd_ok;
  wire        wheel_clear;

  assign rd_ok       = reg_rd && usb_live_r && !usb_bus_reset; // [RQ15]
  assign wheel_clear = rd_ok && (reg_addr == `OFF_WHEEL_COUNT);

  key_debounce u_key_debounce (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .key_raw     (key_raw),
    .key_clean_r (key_clean)
  );

  wheel_counter u_wheel_counter (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .wheel_a     (wheel_a),
    .wheel_b     (wheel_b),
    .count_clear (wheel_clear),
    .count_r     (wheel_val)
  );

  function [7:0] clamp_surface;
    input [7:0] v;
    begin
      clamp_surface = (v > `SURFACE_MAX) ? `SURFACE_MAX : v;
    end
  endfunction

  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `OFF_REVISION:      rdata_nxt = `REVISION_VALUE; // [RQ1]
      `OFF_KEY_STATE:     rdata_nxt = {5'h00, key_clean}; // [RQ2] [RQ3] [RQ16]
      `OFF_HORIZ_LOW:     rdata_nxt = dx_r[7:0]; // [RQ5] [RQ9]
      `OFF_VERT_LOW:      rdata_nxt = x_read_r ? dy_r[7:0] : 8'h00; // [RQ6] [RQ8]
      `OFF_MOTION_UPPER:  rdata_nxt = x_read_r ? {dx_r[11:8], dy_r[11:8]} : 8'h00; // [RQ7] [RQ8]
      `OFF_WHEEL_COUNT:   rdata_nxt = wheel_val; // [RQ17]
      `OFF_SURFACE_COUNT: rdata_nxt = surface_r; // [RQ11]
      `OFF_EXPOSURE_UP:   rdata_nxt = exposure_r[15:8]; // [RQ13]
      `OFF_EXPOSURE_LOW:  rdata_nxt = exp_low_hold_r; // [RQ14]
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_rdata_r    <= 8'h00;
      reg_rvalid_r   <= 1'b0;
      dx_r           <= {4'h0, `RST_MOTION};
      dy_r           <= {4'h0, `RST_MOTION};
      x_read_r       <= 1'b0;
      surface_r      <= `RST_SURFACE;
      exposure_r     <= `RST_EXPOSURE;
      exp_low_hold_r <= `RST_EXPOSURE_LO;
      exp_pair_open_r <= 1'b0;
      usb_live_r     <= 1'b0;
    end
    else if (clk_en)
    begin
      // writes are accepted on the port but alter nothing
      reg_rvalid_r <= rd_ok; // [RQ16]
      if (rd_ok)
        reg_rdata_r <= rdata_nxt;
      if (usb_bus_reset)
      begin
        usb_live_r <= 1'b0; // [RQ15]
        x_read_r   <= 1'b0;
      end
      else
        usb_live_r <= 1'b1;
      // new report data replaces the mirror; reading X arms Y and upper
      if (report_load)
      begin
        dx_r     <= report_dx; // [RQ5]
        dy_r     <= report_dy; // [RQ6]
        x_read_r <= 1'b0;
      end
      else if (rd_ok && reg_addr == `OFF_HORIZ_LOW)
        x_read_r <= 1'b1; // [RQ8]
      if (frame_done)
      begin
        surface_r  <= clamp_surface(frame_features); // [RQ12]
        exposure_r <= frame_exposure; // [RQ13]
      end
      // lower byte is snapped when the upper is read so a frame between reads cannot tear it
      // held until the lower byte is read, else a new frame between the two reads tears the pair
      if (rd_ok && reg_addr == `OFF_EXPOSURE_UP)
      begin
        exp_low_hold_r  <= exposure_r[7:0]; // [RQ14]
        exp_pair_open_r <= 1'b1;
      end
      else
      begin
        if (rd_ok && reg_addr == `OFF_EXPOSURE_LOW)
          exp_pair_open_r <= 1'b0; // [RQ14]
        if (frame_done && !exp_pair_open_r)
          exp_low_hold_r <= frame_exposure[7:0];
      end
    end
  end
endmodule // motion_status_readout

// ==== design/wheel_counter.v ====
// quadrature z-wheel decoder with a saturating signed count, cleared when read
`timescale 1ns/10ps
`include "motion_status_map.vh"
module wheel_counter (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  input  wire       clk_en,
  // wheel
  input  wire       wheel_a,
  input  wire       wheel_b,
  input  wire       count_clear,
  output reg  [7:0] count_r
);
  reg  [1:0] prev_r;
  wire       step;
  wire       up;
  reg  [7:0] count_nxt;
  assign step = ({wheel_a, wheel_b} != prev_r) && (prev_r[0] != wheel_b) && (prev_r[1] == wheel_a) ? 1'b0 :
                ({wheel_a, wheel_b} != prev_r) && (wheel_a != prev_r[1]);
  assign up   = wheel_a ^ wheel_b;
  always @*
  begin
    count_nxt = count_clear ? `RST_WHEEL : count_r;
    // count only on a-edges; clear and step in one cycle keeps the step
    if (step)
    begin
      if (up && count_nxt != `WHEEL_MAX)
        count_nxt = count_nxt + 8'h01; // [RQ10]
      else if (!up && count_nxt != `WHEEL_MIN)
        count_nxt = count_nxt - 8'h01; // [RQ10]
    end
  end
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      prev_r  <= 2'h0;
      count_r <= `RST_WHEEL;
    end
    else if (clk_en)
    begin
      prev_r  <= {wheel_a, wheel_b};
      count_r <= count_nxt; // [RQ17]
    end
  end
endmodule // wheel_counter

// ==== verif/motion_status_readout_properties.sv ====
// register port checks for the motion status readout
`timescale 1ns/10ps
module motion_status_readout_properties (
  // register port
  input wire       clk,
  input wire       reset_n,
  input wire       usb_bus_reset,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_r,
  input wire       reg_rvalid_r
);
  reg  [7:0] la_r;
  wire       v = reg_rvalid_r;
  wire [7:0] q = reg_rdata_r;
  always @(posedge clk)
    la_r <= reg_addr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_answer_cause: assert property (v |-> $past(reg_rd && !usb_bus_reset)) else $error("stray answer");
  a_reset_quiet: assert property (usb_bus_reset |=> !v) else $error("answer in bus reset");
  a_rev_fixed: assert property (v && la_r == 8'h01 |-> q == 8'h01) else $error("revision");
  a_key_reserved: assert property (v && la_r == 8'h02 |-> q[7:3] == 5'h00) else $error("key bits");
  a_surface_cap: assert property (v && la_r == 8'h07 |-> q <= 8'h80) else $error("surface cap");
  a_wheel_range: assert property (v && la_r == 8'h06 |-> q != 8'h80) else $error("wheel range");
  a_unmapped_zero: assert property (v && la_r > 8'h09 |-> q == 8'h00) else $error("unmapped");
  a_data_holds: assert property (!v && !usb_bus_reset |-> $stable(q)) else $error("data moved");
endmodule // motion_status_readout_properties
bind motion_status_readout motion_status_readout_properties props (.clk(clk), .reset_n(reset_n),
  .usb_bus_reset(usb_bus_reset), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata_r(reg_rdata_r),
  .reg_rvalid_r(reg_rvalid_r));

// ==== verif/motion_status_register_readout_bench.sv ====
// self-checking bench for the motion status readout
`timescale 1ns/10ps
module motion_status_register_readout_bench;
  reg         clk = 1'b0, reset_n = 1'b0, wheel_a = 1'b0, wheel_b = 1'b0, report_load = 1'b0, frame_done = 1'b0;
  reg  [2:0]  key_raw = 3'h0;
  reg  [11:0] report_dx = 12'h000, report_dy = 12'h000;
  reg  [7:0]  frame_features = 8'h00, d;
  reg  [15:0] frame_exposure = 16'h0000;
  wire        reg_rd, reg_wr, usb_bus_reset, reg_rvalid_r;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata_r;
  integer     mismatches = 0, compares = 0, cycles = 0, i;
  always #12.5 clk = ~clk;
  motion_status_readout uut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .usb_bus_reset(usb_bus_reset),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .key_raw(key_raw), .wheel_a(wheel_a), .wheel_b(wheel_b),
    .report_load(report_load), .report_dx(report_dx), .report_dy(report_dy), .frame_done(frame_done),
    .frame_features(frame_features), .frame_exposure(frame_exposure));
  usb_host_model host (.clk(clk), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .usb_bus_reset(usb_bus_reset));
  task rc(input [7:0] a, input [7:0] exp, input w = 1'b0);
    host.acc(w, a, 8'h5a, d);
    compares++;
    mismatches += (d !== exp);
    if (d !== exp)
      $display("mismatch %0t got %h exp %h", $time, d, exp);
  endtask
  task t_idle;
    host.bus_reset(1'b1);
    rc(8'h01, 8'hxx);
    host.bus_reset(1'b0);
    repeat (2) @(posedge clk);
    rc(8'h01, 8'h01);
    rc(8'h08, 8'h00);
    rc(8'h09, 8'h64);
    rc(8'h20, 8'h00);
    rc(8'h03, 8'hxx, 1'b1);
    rc(8'h03, 8'h00);
  endtask
  task t_motion;
    @(posedge clk);
    {report_load, report_dx, report_dy} <= {1'b1, 24'h9a53c7};
    @(posedge clk);
    report_load <= 1'b0;
    rc(8'h04, 8'h00);
    rc(8'h05, 8'h00);
    rc(8'h03, 8'ha5);
    rc(8'h04, 8'hc7);
    rc(8'h05, 8'h93);
    @(posedge clk);
    key_raw <= 3'b101;
    repeat (20) @(posedge clk);
    rc(8'h02, 8'h00);
    repeat (200) @(posedge clk);
    rc(8'h02, 8'h05);
  endtask
  // seq holds the four quadrature phases, two bits each
  task spin(input [7:0] seq, input [7:0] exp);
    for (i = 0; i < 640; i++)
    begin
      @(posedge clk);
      {wheel_a, wheel_b} <= seq[2 * (i % 4) +: 2];
      repeat (7) @(posedge clk);
    end
    rc(8'h06, exp);
    rc(8'h06, 8'h00);
  endtask
  task t_image;
    @(posedge clk);
    {frame_done, frame_features, frame_exposure} <= {1'b1, 8'hc8, 16'h1234};
    @(posedge clk);
    frame_done <= 1'b0;
    rc(8'h07, 8'h80);
    rc(8'h08, 8'h12);
    @(posedge clk);
    {frame_done, frame_features, frame_exposure} <= {1'b1, 8'h3c, 16'h5678};
    @(posedge clk);
    frame_done <= 1'b0;
    rc(8'h09, 8'h34);
    rc(8'h07, 8'h3c);
    rc(8'h08, 8'h56);
    rc(8'h09, 8'h78);
  endtask
  task final_report(input hang);
    mismatches += hang;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
    if (++cycles == 20000) final_report(1'b1);
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_idle;
    t_motion;
    spin(8'h1e, 8'h7f);
    spin(8'h2d, 8'h81);
    t_image;
    final_report(1'b0);
  end
endmodule // motion_status_register_readout_bench

// ==== verif/usb_host_model.sv ====
// usb host model making register reads and writes
`timescale 1ns/10ps
module usb_host_model (
  // register port
  input  wire       clk,
  input  wire [7:0] reg_rdata_r,
  input  wire       reg_rvalid_r,
  output reg        reg_rd = 1'b0,
  output reg        reg_wr = 1'b0,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  output reg        usb_bus_reset = 1'b0
);
  // released lines show the inverse so stale values never pass; d is x when no answer came
  task acc(input w, input [7:0] a, input [7:0] v, output [7:0] d);
    @(posedge clk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} <= {!w, w, a, v};
    @(posedge clk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'b00, ~a, ~v};
    #1 d = reg_rvalid_r ? reg_rdata_r : 8'hxx;
  endtask
  task bus_reset(input r);
    @(posedge clk);
    usb_bus_reset <= r;
  endtask
endmodule // usb_host_model
